//--- cmu_top.sv
// AXI4-Lite register front end of the two capture/compare/modulation units.
`timescale 1ns/1ns
`default_nettype none
module cmu_top (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // AXI4-Lite write channels.
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   output logic [1:0] s_axi_bresp_o,
   // AXI4-Lite read channels.
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   input wire logic [7:0] s_axi_araddr_i,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   // Time bases, synchronous to clock_i.
   input wire logic [15:0] first_timer_count_i,
   input wire logic [15:0] third_timer_count_i,
   input wire logic [9:0] pwm_count_i,
   input wire logic pwm_period_i,
   // Unit pins.
   input wire logic [1:0] capture_pin_i,
   output logic [1:0] unit_pin_o,
   output logic [1:0] unit_own_pin_o,
   // Flags and gated requests.
   output logic [1:0] unit_interrupt_flag_o,
   output logic [1:0] unit_irq_o
);
   typedef enum logic {W_IDLE, W_RESP} cmu_wstate_t;
   cmu_wstate_t wstate_reg, wstate_next;
   logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
   logic awready_reg, awready_next, wready_reg, wready_next;
   logic [7:0] awaddr_reg, awaddr_next;
   logic [7:0] wdata_reg, wdata_next;
   logic wstrb_reg, wstrb_next;
   logic [1:0] bresp_reg, bresp_next;
   logic arready_reg, arready_next, rvalid_reg, rvalid_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] rresp_reg, rresp_next;
   logic [1:0] assign_reg, assign_next;
   logic [1:0] ien_reg, ien_next;
   logic [1:0] irq_reg, irq_next;
   logic timer_sel;
   logic hit;
   logic [7:0] base;
   cmu_pkg::cmu_wr_t wr [cmu_pkg::NUM_UNITS];
   cmu_pkg::cmu_stat_t stat [cmu_pkg::NUM_UNITS];
   logic [1:0] flags;

   ////////////////////////////////////////////////////////////////////////////////
   // Units four and five share every time base; either assignment bit moves both to the third timer.
   assign timer_sel = assign_reg[0] || assign_reg[1];

   for (genvar u = 0; u < cmu_pkg::NUM_UNITS; u++) begin : g_unit
      cmu_unit unit_i (
         .clock_i(clock_i),
         .rst_i(rst_i),
         .wr_i(wr[u]),
         .timer_sel_i(timer_sel),
         .first_timer_count_i(first_timer_count_i),
         .third_timer_count_i(third_timer_count_i),
         .capture_pin_i(capture_pin_i[u]),
         .pwm_count_i(pwm_count_i),
         .pwm_period_i(pwm_period_i),
         .stat_o(stat[u]),
         .pin_o(unit_pin_o[u]),
         .own_pin_o(unit_own_pin_o[u])
      );
      assign flags[u] = stat[u].flag;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Write path: address and data are held separately, then applied together.
   always_comb begin
      wstate_next = wstate_reg;
      aw_held_next = aw_held_reg;
      w_held_next = w_held_reg;
      awaddr_next = awaddr_reg;
      wdata_next = wdata_reg;
      wstrb_next = wstrb_reg;
      bresp_next = bresp_reg;
      assign_next = assign_reg;
      ien_next = ien_reg;
      hit = 1'b0;
      base = 8'h00;
      for (int u = 0; u < cmu_pkg::NUM_UNITS; u++) begin
         wr[u] = '{ctrl_we: 1'b0, low_we: 1'b0, high_we: 1'b0, flag_clr: 1'b0, data: wdata_reg};
      end
      if (s_axi_awvalid_i && awready_reg) begin
         awaddr_next = s_axi_awaddr_i;
         aw_held_next = 1'b1;
      end
      if (s_axi_wvalid_i && wready_reg) begin
         wdata_next = s_axi_wdata_i[7:0];
         wstrb_next = s_axi_wstrb_i[0];
         w_held_next = 1'b1;
      end
      case (wstate_reg)
         W_IDLE: begin
            if (aw_held_reg && w_held_reg) begin
               aw_held_next = 1'b0;
               w_held_next = 1'b0;
               wstate_next = W_RESP;
               for (int u = 0; u < cmu_pkg::NUM_UNITS; u++) begin
                  base = 8'(u) * cmu_pkg::UNIT_STRIDE;
                  if (awaddr_reg == base + cmu_pkg::OFF_CTRL) begin
                     wr[u].ctrl_we = wstrb_reg;
                     hit = 1'b1;
                  end
                  if (awaddr_reg == base + cmu_pkg::OFF_LOW) begin
                     wr[u].low_we = wstrb_reg;
                     hit = 1'b1;
                  end
                  if (awaddr_reg == base + cmu_pkg::OFF_HIGH) begin
                     wr[u].high_we = wstrb_reg;
                     hit = 1'b1;
                  end
                  // Flags clear by writing one; a set in the same cycle still wins.
                  if (awaddr_reg == cmu_pkg::OFF_FLAGS) begin
                     wr[u].flag_clr = wstrb_reg && wdata_reg[u];
                  end
               end
               if (awaddr_reg == cmu_pkg::OFF_ASSIGN) begin
                  hit = 1'b1;
                  if (wstrb_reg) begin
                     assign_next = wdata_reg[1:0];
                  end
               end
               if (awaddr_reg == cmu_pkg::OFF_FLAGS) begin
                  hit = 1'b1;
               end
               if (awaddr_reg == cmu_pkg::OFF_IEN) begin
                  hit = 1'b1;
                  if (wstrb_reg) begin
                     ien_next = wdata_reg[1:0];
                  end
               end
               bresp_next = hit ? cmu_pkg::RESP_OKAY : cmu_pkg::RESP_SLVERR;
            end
         end
         W_RESP: begin
            if (s_axi_bready_i) begin
               wstate_next = W_IDLE;
            end
         end
         default: wstate_next = W_IDLE;
      endcase
      awready_next = !aw_held_next;
      wready_next = !w_held_next;
      // Soft-interrupt mode relies on this gate; the flag itself is never masked.
      irq_next = flags & ien_reg;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: one read at a time, answered the cycle after the address is taken.
   always_comb begin
      arready_next = arready_reg;
      rvalid_next = rvalid_reg;
      rdata_next = rdata_reg;
      rresp_next = rresp_reg;
      if (rvalid_reg && s_axi_rready_i) begin
         rvalid_next = 1'b0;
         arready_next = 1'b1;
      end
      if (s_axi_arvalid_i && arready_reg) begin
         arready_next = 1'b0;
         rvalid_next = 1'b1;
         rdata_next = 32'h0000_0000;
         rresp_next = cmu_pkg::RESP_SLVERR;
         for (int u = 0; u < cmu_pkg::NUM_UNITS; u++) begin
            if (s_axi_araddr_i == 8'(u) * cmu_pkg::UNIT_STRIDE + cmu_pkg::OFF_CTRL) begin
               rdata_next = {26'h0, stat[u].ctrl};
               rresp_next = cmu_pkg::RESP_OKAY;
            end
            if (s_axi_araddr_i == 8'(u) * cmu_pkg::UNIT_STRIDE + cmu_pkg::OFF_LOW) begin
               rdata_next = {24'h0, stat[u].value[7:0]};
               rresp_next = cmu_pkg::RESP_OKAY;
            end
            if (s_axi_araddr_i == 8'(u) * cmu_pkg::UNIT_STRIDE + cmu_pkg::OFF_HIGH) begin
               rdata_next = {24'h0, stat[u].value[15:8]};
               rresp_next = cmu_pkg::RESP_OKAY;
            end
         end
         if (s_axi_araddr_i == cmu_pkg::OFF_ASSIGN) begin
            rdata_next = {30'h0, assign_reg};
            rresp_next = cmu_pkg::RESP_OKAY;
         end
         if (s_axi_araddr_i == cmu_pkg::OFF_FLAGS) begin
            rdata_next = {30'h0, flags};
            rresp_next = cmu_pkg::RESP_OKAY;
         end
         if (s_axi_araddr_i == cmu_pkg::OFF_IEN) begin
            rdata_next = {30'h0, ien_reg};
            rresp_next = cmu_pkg::RESP_OKAY;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wstate_reg <= W_IDLE;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 8'h00;
         wstrb_reg <= 1'b0;
         bresp_reg <= cmu_pkg::RESP_OKAY;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= cmu_pkg::RESP_OKAY;
         assign_reg <= cmu_pkg::ASSIGN_RST;
         ien_reg <= 2'h0;
         irq_reg <= 2'h0;
      end else begin
         wstate_reg <= wstate_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= awready_next;
         wready_reg <= wready_next;
         awaddr_reg <= awaddr_next;
         wdata_reg <= wdata_next;
         wstrb_reg <= wstrb_next;
         bresp_reg <= bresp_next;
         arready_reg <= arready_next || (!rvalid_next && !arready_reg && !rvalid_reg);
         rvalid_reg <= rvalid_next;
         rdata_reg <= rdata_next;
         rresp_reg <= rresp_next;
         assign_reg <= assign_next;
         ien_reg <= ien_next;
         irq_reg <= irq_next;
      end
   end

   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o = wready_reg;
   assign s_axi_bvalid_o = wstate_reg == W_RESP;
   assign s_axi_bresp_o = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o = rvalid_reg;
   assign s_axi_rdata_o = rdata_reg;
   assign s_axi_rresp_o = rresp_reg;
   assign unit_interrupt_flag_o = flags;
   assign unit_irq_o = irq_reg;

   a_irq_follows_flag: assert property (@(posedge clock_i) disable iff (rst_i)
      flags[0] && ien_reg[0] |=> unit_irq_o[0])
      else $error("enabled flag did not raise the request");
endmodule
`default_nettype wire

//--- cmu_pkg.sv
// Constants and types shared by the capture/compare/modulation unit pair.
// Notes on behaviour
// - In compare mode each unit keeps comparing its 16-bit value with the selected timer count.
// - A compare match drives the pin high, drives it low, toggles it or leaves it, as the mode says.
// - The interrupt flag is set in the same cycle in which a match acts on the pin.
// - Mode 1010 leaves the pin untouched and only raises an interrupt when it is enabled.
// - Writing zero to a control register forces that unit's own compare output latch low.
// - In modulation mode the pin carries a waveform with up to 10 bits of duty resolution.
// - Clearing either control register forces that unit's modulation output latch low.
// - The 4-bit mode field decodes to off, toggle, set-high, set-low, soft interrupt, capture and modulation.
// - A capture event loads the timer count into the value register, overwriting, and sets the flag.
// - The capture prescaler counter is cleared whenever the unit is off or not capturing.
// - The timer serving each unit follows the two timer-assignment bits.
package cmu_pkg;
   localparam int NUM_UNITS = 2;
   localparam int ADDR_W = 8;
   // Byte offsets of the register map.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_LOW = 8'h04;
   localparam logic [7:0] OFF_HIGH = 8'h08;
   localparam logic [7:0] UNIT_STRIDE = 8'h0C;
   localparam logic [7:0] OFF_ASSIGN = 8'h18;
   localparam logic [7:0] OFF_FLAGS = 8'h1C;
   localparam logic [7:0] OFF_IEN = 8'h20;
   // Control register fields.
   localparam int MODE_LSB = 0;
   localparam int DUTY_LSB = 4;
   localparam logic [5:0] CTRL_RST = 6'h00;
   localparam logic [15:0] VALUE_RST = 16'h0000;
   localparam logic [1:0] ASSIGN_RST = 2'h0;
   // Mode field codes.
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_TOGGLE = 4'h2;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_4TH = 4'h6;
   localparam logic [3:0] MODE_CAP_16TH = 4'h7;
   localparam logic [3:0] MODE_SET_HIGH = 4'h8;
   localparam logic [3:0] MODE_SET_LOW = 4'h9;
   localparam logic [3:0] MODE_SOFT = 4'hA;
   localparam logic [1:0] CAP_PREFIX = 2'h1;
   localparam logic [1:0] PWM_PREFIX = 2'h3;
   localparam logic [3:0] PRESC_4TH_LAST = 4'h3;
   localparam logic [3:0] PRESC_16TH_LAST = 4'hF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic ctrl_we;
      logic low_we;
      logic high_we;
      logic flag_clr;
      logic [7:0] data;
   } cmu_wr_t;

   typedef struct packed {
      logic [5:0] ctrl;
      logic [15:0] value;
      logic flag;
   } cmu_stat_t;
endpackage

//--- cmu_unit.sv
// One capture/compare/modulation unit with its control, value and flag state.
`timescale 1ns/1ns
`default_nettype none
module cmu_unit (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // Register writes and timer choice.
   input wire cmu_pkg::cmu_wr_t wr_i,
   input wire logic timer_sel_i,
   // Time bases and capture input.
   input wire logic [15:0] first_timer_count_i,
   input wire logic [15:0] third_timer_count_i,
   input wire logic capture_pin_i,
   input wire logic [9:0] pwm_count_i,
   input wire logic pwm_period_i,
   // State and pin.
   output cmu_pkg::cmu_stat_t stat_o,
   output logic pin_o,
   output logic own_pin_o
);
   logic [5:0] ctrl_reg, ctrl_next;
   logic [15:0] value_reg, value_next;
   logic flag_reg, flag_next;
   logic pin_reg, pin_next;
   logic own_reg, own_next;
   logic match_prev_reg, match_prev_next;
   logic cap_prev_reg, cap_prev_next;
   logic [3:0] presc_reg, presc_next;
   logic [1:0] duty_lsb_reg, duty_lsb_next;
   logic [3:0] mode, new_mode;
   logic [15:0] count;
   logic is_cmp, is_cap, is_pwm, match, match_evt, rise, fall, cap_evt, set;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      mode = ctrl_reg[cmu_pkg::MODE_LSB +: 4];
      new_mode = wr_i.data[cmu_pkg::MODE_LSB +: 4];
      count = timer_sel_i ? third_timer_count_i : first_timer_count_i;
      is_cmp = (mode == cmu_pkg::MODE_TOGGLE) || (mode == cmu_pkg::MODE_SET_HIGH) ||
               (mode == cmu_pkg::MODE_SET_LOW) || (mode == cmu_pkg::MODE_SOFT);
      is_cap = mode[3:2] == cmu_pkg::CAP_PREFIX;
      is_pwm = mode[3:2] == cmu_pkg::PWM_PREFIX;
      // A held timer value matches for many cycles; only its first cycle acts.
      match = is_cmp && (value_reg == count);
      match_evt = match && !match_prev_reg;
      rise = capture_pin_i && !cap_prev_reg;
      fall = !capture_pin_i && cap_prev_reg;
      case (mode)
         cmu_pkg::MODE_CAP_FALL: cap_evt = fall;
         cmu_pkg::MODE_CAP_RISE: cap_evt = rise;
         cmu_pkg::MODE_CAP_4TH: cap_evt = rise && (presc_reg == cmu_pkg::PRESC_4TH_LAST);
         cmu_pkg::MODE_CAP_16TH: cap_evt = rise && (presc_reg == cmu_pkg::PRESC_16TH_LAST);
         default: cap_evt = 1'b0;
      endcase
      ctrl_next = ctrl_reg;
      value_next = value_reg;
      pin_next = pin_reg;
      presc_next = presc_reg;
      duty_lsb_next = duty_lsb_reg;
      match_prev_next = match;
      cap_prev_next = capture_pin_i;
      set = 1'b0;
      if (wr_i.ctrl_we) begin
         ctrl_next = wr_i.data[5:0];
         // A prescaler switch without an off step keeps the count running.
         if (new_mode[3:2] != cmu_pkg::CAP_PREFIX) begin
            presc_next = 4'h0;
         end
         case (new_mode)
            cmu_pkg::MODE_OFF: pin_next = 1'b0;
            cmu_pkg::MODE_SET_HIGH: pin_next = 1'b0;
            cmu_pkg::MODE_SET_LOW: pin_next = 1'b1;
            default: pin_next = pin_reg;
         endcase
      end else begin
         if (!is_cap) begin
            presc_next = 4'h0;
         end else if (rise && (mode == cmu_pkg::MODE_CAP_4TH || mode == cmu_pkg::MODE_CAP_16TH)) begin
            presc_next = (presc_reg == cmu_pkg::PRESC_4TH_LAST && mode == cmu_pkg::MODE_CAP_4TH)
                         ? 4'h0 : presc_reg + 4'h1;
         end
         if (cap_evt) begin
            value_next = count;
            set = 1'b1;
         end
         if (match_evt) begin
            set = 1'b1;
            case (mode)
               cmu_pkg::MODE_TOGGLE: pin_next = !pin_reg;
               cmu_pkg::MODE_SET_HIGH: pin_next = 1'b1;
               cmu_pkg::MODE_SET_LOW: pin_next = 1'b0;
               default: pin_next = pin_reg;
            endcase
         end
         if (is_pwm) begin
            // Duty is double-buffered: the high byte and two-bit latch change only per period.
            if (pwm_period_i) begin
               value_next[15:8] = value_reg[7:0];
               duty_lsb_next = ctrl_reg[cmu_pkg::DUTY_LSB +: 2];
               pin_next = {value_reg[7:0], ctrl_reg[cmu_pkg::DUTY_LSB +: 2]} != 10'h000;
            end else if (pwm_count_i == {value_reg[15:8], duty_lsb_reg}) begin
               pin_next = 1'b0;
            end
         end
      end
      if (wr_i.low_we) begin
         value_next[7:0] = wr_i.data;
      end
      if (wr_i.high_we && !is_pwm) begin
         value_next[15:8] = wr_i.data;
      end
      flag_next = set || (flag_reg && !wr_i.flag_clr);
      own_next = (ctrl_next[3:0] == cmu_pkg::MODE_TOGGLE) || (ctrl_next[3:2] == cmu_pkg::PWM_PREFIX) ||
                 (ctrl_next[3:0] == cmu_pkg::MODE_SET_HIGH) || (ctrl_next[3:0] == cmu_pkg::MODE_SET_LOW);
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= cmu_pkg::CTRL_RST;
         value_reg <= cmu_pkg::VALUE_RST;
         flag_reg <= 1'b0;
         pin_reg <= 1'b0;
         own_reg <= 1'b0;
         match_prev_reg <= 1'b0;
         cap_prev_reg <= 1'b0;
         presc_reg <= 4'h0;
         duty_lsb_reg <= 2'h0;
      end else begin
         ctrl_reg <= ctrl_next;
         value_reg <= value_next;
         flag_reg <= flag_next;
         pin_reg <= pin_next;
         own_reg <= own_next;
         match_prev_reg <= match_prev_next;
         cap_prev_reg <= cap_prev_next;
         presc_reg <= presc_next;
         duty_lsb_reg <= duty_lsb_next;
      end
   end

   assign stat_o = '{ctrl: ctrl_reg, value: value_reg, flag: flag_reg};
   assign pin_o = pin_reg;
   assign own_pin_o = own_reg;

   ////////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_match_sets_flag: assert property (match_evt && !wr_i.ctrl_we |=> flag_reg)
      else $error("compare match did not set the flag");
   a_toggle_on_match: assert property (mode == cmu_pkg::MODE_TOGGLE && match_evt && !wr_i.ctrl_we
      |=> pin_reg != $past(pin_reg))
      else $error("toggle mode did not toggle on match");
   a_high_on_match: assert property (mode == cmu_pkg::MODE_SET_HIGH && match && !match_prev_reg
      && !wr_i.ctrl_we |=> pin_reg && flag_reg)
      else $error("set-high mode missed a match");
   a_soft_keeps_pin: assert property (mode == cmu_pkg::MODE_SOFT && !wr_i.ctrl_we
      |=> $stable(pin_reg))
      else $error("soft interrupt mode moved the pin");
   a_off_pin_low: assert property (wr_i.ctrl_we && wr_i.data[3:0] == cmu_pkg::MODE_OFF
      |=> !pin_reg && presc_reg == 4'h0 ##1 !pin_reg)
      else $error("clearing control left the output latch high");
   a_flag_sticky: assert property (flag_reg && !wr_i.flag_clr |=> flag_reg)
      else $error("flag dropped without a clear");
   a_capture_load: assert property (cap_evt && !wr_i.ctrl_we && !wr_i.low_we && !wr_i.high_we
      |=> value_reg == $past(count) && flag_reg)
      else $error("capture did not load the timer count");
   a_presc_clear: assert property (!is_cap && !wr_i.ctrl_we |=> presc_reg == 4'h0)
      else $error("prescaler not cleared outside capture");
   a_pwm_period: assert property (is_pwm && pwm_period_i && !wr_i.ctrl_we
      && {value_reg[7:0], ctrl_reg[5:4]} != 10'h000 |=> pin_reg)
      else $error("modulated output not set at period start");
endmodule
`default_nettype wire

//--- cmu_timer_model.sv
// Timer counts and modulation time base that feed the unit pair.
`timescale 1ns/1ns
`default_nettype none
module cmu_timer_model (
   // Clock and reset.
   input wire logic clock_i,
   input wire logic rst_i,
   // Time bases.
   output logic [15:0] first_timer_count_o,
   output logic [15:0] third_timer_count_o,
   output logic [9:0] pwm_count_o,
   output logic pwm_period_o
);
   // Counting on the system clock keeps the compare path synchronous.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         first_timer_count_o <= 16'h0000;
      end else begin
         first_timer_count_o <= {10'h000, first_timer_count_o[5:0] + 6'h01};
      end
   end
   // The third timer runs in a range the first never reaches, so a match proves the choice.
   assign third_timer_count_o = first_timer_count_o + 16'h1000;
   assign pwm_count_o = first_timer_count_o[9:0];
   assign pwm_period_o = (first_timer_count_o[5:0] == 6'h3F);
endmodule
`default_nettype wire

//--- cmu_top_tb.sv
// Register-level bench of the capture/compare/modulation unit pair.
`timescale 1ns/1ns
`default_nettype none
module cmu_top_tb;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata, rd;
   logic [1:0] cap = 2'h0, bresp, rresp, rsp, pin, own, flag, irq;
   logic awready, wready, bvalid, arready, rvalid, pwm_period;
   logic [15:0] t1, t3;
   logic [9:0] pwm_count;
   logic [3:0] modes [4] = '{cmu_pkg::MODE_SET_HIGH, cmu_pkg::MODE_SET_LOW,
      cmu_pkg::MODE_TOGGLE, cmu_pkg::MODE_SOFT};
   int fails = 0, samples_checked = 0, hi;
   initial forever #2 clock_i = ~clock_i;
   cmu_timer_model tmr_u (.clock_i(clock_i), .rst_i(rst_i), .first_timer_count_o(t1),
      .third_timer_count_o(t3), .pwm_count_o(pwm_count), .pwm_period_o(pwm_period));
   cmu_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .s_axi_awvalid_i(awvalid),
      .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(1'b1), .s_axi_bresp_o(bresp),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(1'b1), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .first_timer_count_i(t1), .third_timer_count_i(t3),
      .pwm_count_i(pwm_count), .pwm_period_i(pwm_period), .capture_pin_i(cap),
      .unit_pin_o(pin), .unit_own_pin_o(own), .unit_interrupt_flag_o(flag),
      .unit_irq_o(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Response channels keep ready high throughout, so only the requests move.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      forever begin
         @(posedge clock_i);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      rsp = bresp;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      forever begin
         @(posedge clock_i);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rd = rdata;
      rsp = rresp;
   endtask
   task automatic wrap_up;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      wrap_up();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      rd_reg(cmu_pkg::OFF_CTRL);
      chk(rd, 32'h00000000);
      rd_reg(8'h40);
      chk(32'(rsp), 32'(cmu_pkg::RESP_SLVERR));
      wr(cmu_pkg::OFF_LOW, 8'h20);
      // The high byte parks the value out of the timer's range until the mode is set.
      for (int i = 0; i < 4; i++) begin
         wr(cmu_pkg::OFF_CTRL, 8'h00);
         chk(32'(pin[0]), 32'h0);
         wr(cmu_pkg::OFF_HIGH, 8'h01);
         wr(cmu_pkg::OFF_FLAGS, 8'h01);
         wr(cmu_pkg::OFF_CTRL, {4'h0, modes[i]});
         chk(32'(pin[0]), 32'(4'h2 >> i) & 32'h1);
         chk(32'(own[0]), 32'(4'h7 >> i) & 32'h1);
         wr(cmu_pkg::OFF_HIGH, 8'h00);
         // Stop at the first match, so a toggle is not seen twice in the 70-cycle wait, which is longer than one 64-count timer lap.
         for (int k = 0; k < 70 && flag[0] !== 1'b1; k++) @(posedge clock_i);
         chk(32'(pin[0]), 32'(4'h5 >> i) & 32'h1);
         chk(32'(flag[0]), 32'h1);
         chk(32'(irq[0]), 32'h0);
      end
      repeat (64) @(posedge clock_i);
      chk(32'(flag[0]), 32'h1);
      wr(cmu_pkg::OFF_IEN, 8'h01);
      repeat (2) @(posedge clock_i);
      chk(32'(irq[0]), 32'h1);
      wr(cmu_pkg::OFF_LOW + cmu_pkg::UNIT_STRIDE, 8'h10);
      wr(cmu_pkg::OFF_HIGH + cmu_pkg::UNIT_STRIDE, 8'h10);
      wr(cmu_pkg::OFF_ASSIGN, 8'h01);
      wr(cmu_pkg::UNIT_STRIDE, 8'h08);
      repeat (64) @(posedge clock_i);
      chk(32'(pin[1] & flag[1]), 32'h1);
      wr(cmu_pkg::OFF_CTRL, 8'h00);
      wr(cmu_pkg::OFF_LOW, 8'h08);
      wr(cmu_pkg::OFF_CTRL, 8'h0C);
      repeat (128) @(posedge clock_i);
      hi = 0;
      repeat (64) begin
         @(posedge clock_i);
         if (pin[0] === 1'b1) hi++;
      end
      chk(32'(hi >= 31 && hi <= 33), 32'h1);
      chk(32'(own[0]), 32'h1);
      wr(cmu_pkg::OFF_CTRL, 8'h00);
      chk(32'({own[0], pin[0]}), 32'h0);
      wr(cmu_pkg::OFF_FLAGS, 8'h03);
      wr(cmu_pkg::OFF_CTRL, {4'h0, cmu_pkg::MODE_CAP_RISE});
      cap <= 2'h1;
      repeat (4) @(posedge clock_i);
      chk(32'(flag[0]), 32'h1);
      // Both units now follow the third timer, whose count always has 8'h10 as its high byte.
      rd_reg(cmu_pkg::OFF_HIGH);
      chk(rd, 32'h00000010);
      wr(cmu_pkg::OFF_CTRL, 8'h00);
      wr(cmu_pkg::OFF_FLAGS, 8'h01);
      wr(cmu_pkg::OFF_CTRL, {4'h0, cmu_pkg::MODE_CAP_4TH});
      for (int k = 0; k < 4; k++) begin
         chk(32'(flag[0]), 32'h0);
         cap <= 2'h0;
         repeat (2) @(posedge clock_i);
         cap <= 2'h1;
         repeat (2) @(posedge clock_i);
      end
      chk(32'(flag[0]), 32'h1);
      wrap_up();
   end
endmodule
`default_nettype wire
